// file: verilog/tpwm_top.sv
// 16-bit pwm timer: free-running toggle, triangular pwm and high-accuracy modes
// assumes one apb clock pclk, registers over apb, pins to external gate drivers
// Behaviour
// - period match when counter equals period compare 0
// - duty match on step value to value+1
// - free mode toggles outputs on each match
// - free mode outputs go active at start
// - triangle mode gives variable-duty pwm outputs
// - triangle mode direction out inactive up, active down
// - match irq when counter equals compare
// - trough irq on underflow
// - buffered compares load at underflow
// - writing duty one arms next reload
// - no reload without trough reload enable
// - code 0111 selects triangle mode
// - count up to period then down
// - duty period+1 zero, zero full
// - reload and irq thinning when all set
// - irq thinning whether rde is set or clear
// - code 1000 selects high-accuracy mode
// - three-phase pwm on six pins, counter steps by two
// - count from dt0 up to period-dt1
// - dead-time counters reload on match
// - compare match never clears counter
// - code 0101 free mode, 0000H to FFFFH
// - overflow sets flag, cleared by write0/stop
`timescale 1ns/100ps
`default_nettype none
`include "tpwm_regs.svh"
module tpwm_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic direction_out,
  output logic [4:0] pwm_outputs_1_to_5,
  output logic [5:0] deadtime_phase_out,
  output logic [5:0] match_irqs,
  output logic overflow_irq,
  output logic trough_irq,
  output logic peak_irq
);
  // =====================================================================
  // registers
  logic count_run_bit_q;
  logic [3:0] mode_select_field_q;
  logic trough_reload_enable_q, peak_reload_enable_q, peak_irq_enable_q, reload_thinning_enable_q;
  logic [4:0] irq_thinning_count_q;
  logic [9:0] deadtime_neg_to_pos_q, deadtime_pos_to_neg_q;
  logic overflow_flag_q;
  logic arm_q;
  logic [4:0] thin_q;
  logic [15:0] cnt_q;
  logic down_q;
  logic [5:0] outs_q;
  logic [95:0] cmp_buf, cmp_act;
  logic [5:0] cmp_wr;
  logic cmp_load;
  logic wr_en;
  tpwm_pkg::mode_t mode;

  // decode the mode field
  function automatic tpwm_pkg::mode_t decode_mode(input logic [3:0] f);
    if (f == `TPWM_MODE_FREE)
      decode_mode = tpwm_pkg::MODE_FREE;
    else if (f == `TPWM_MODE_TRI)
      decode_mode = tpwm_pkg::MODE_TRI;
    else if (f == `TPWM_MODE_HACC)
      decode_mode = tpwm_pkg::MODE_HACC;
    else
      decode_mode = tpwm_pkg::MODE_IDLE;
  endfunction

  function automatic logic [15:0] cmp_of(input logic [95:0] v, input int k);
    cmp_of = v[16*k +: 16];
  endfunction

  assign mode = decode_mode(mode_select_field_q);
  assign wr_en = psel && penable && pwrite;

  // =====================================================================
  // apb: zero wait states, unmapped reads zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
    end
  end

  // compare write strobes by word index
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_wr
      assign cmp_wr[gi] = wr_en && pready && (paddr == `TPWM_CMP0_OFS + 12'(4 * gi));
    end
  endgenerate

  // control and option registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_run_bit_q <= 1'b0;
      mode_select_field_q <= 4'h0;
      trough_reload_enable_q <= 1'b0;
      peak_reload_enable_q <= 1'b0;
      peak_irq_enable_q <= 1'b0;
      reload_thinning_enable_q <= 1'b0;
      irq_thinning_count_q <= 5'h00;
      deadtime_neg_to_pos_q <= `TPWM_DT_RST;
      deadtime_pos_to_neg_q <= `TPWM_DT_RST;
    end
    else if (wr_en && pready)
    begin
      if (paddr == `TPWM_CTRL_OFS)
      begin
        count_run_bit_q <= pwdata[`TPWM_RUN_BIT];
        mode_select_field_q <= pwdata[`TPWM_MODE_LSB +: 4];
      end
      if (paddr == `TPWM_OPT_OFS)
      begin
        trough_reload_enable_q <= pwdata[`TPWM_RBE_BIT];
        peak_reload_enable_q <= pwdata[`TPWM_RTE_BIT];
        peak_irq_enable_q <= pwdata[`TPWM_ICE_BIT];
        reload_thinning_enable_q <= pwdata[`TPWM_RDE_BIT];
        irq_thinning_count_q <= pwdata[`TPWM_ID_LSB +: 5];
      end
      if (paddr == `TPWM_DT0_OFS)
        deadtime_neg_to_pos_q <= pwdata[9:0];
      if (paddr == `TPWM_DT1_OFS)
        deadtime_pos_to_neg_q <= pwdata[9:0];
    end
  end

  // read mux
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      prdata <= 32'h00000000;
      unique case (paddr)
        `TPWM_CTRL_OFS: prdata <= {24'h000000, mode_select_field_q, 3'h0, count_run_bit_q};
        `TPWM_OPT_OFS: prdata <= {19'h00000, irq_thinning_count_q, 4'h0, reload_thinning_enable_q,
                                  peak_irq_enable_q, peak_reload_enable_q, trough_reload_enable_q};
        `TPWM_STAT_OFS: prdata <= {29'h00000000, arm_q, down_q, overflow_flag_q};
        `TPWM_CNT_OFS: prdata <= {16'h0000, cnt_q};
        `TPWM_DT0_OFS: prdata <= {22'h000000, deadtime_neg_to_pos_q};
        `TPWM_DT1_OFS: prdata <= {22'h000000, deadtime_pos_to_neg_q};
        `TPWM_OUT_OFS: prdata <= {26'h0000000, outs_q};
        default:
        begin
          if (paddr >= `TPWM_CMP0_OFS && paddr < `TPWM_DT0_OFS && paddr[1:0] == 2'b00)
            prdata <= {16'h0000, cmp_of(cmp_buf, int'(paddr[5:2]) - 4)};
        end
      endcase
    end
  end

  // =====================================================================
  // compare registers: anytime rewrite outside triangle mode
  cmp_bank #(.N(6)) u_cmp (
    .pclk(pclk),
    .presetn(presetn),
    .wr(cmp_wr),
    .wdata(pwdata[15:0]),
    .direct(mode != tpwm_pkg::MODE_TRI),
    .load(cmp_load),
    .buf_out(cmp_buf),
    .act_out(cmp_act)
  );

  // =====================================================================
  // counter events
  logic [15:0] per;
  logic underflow, peak, free_wrap;
  logic [15:0] hi_lim;
  assign per = cmp_of(cmp_act, 0);
  assign hi_lim = per - {6'h00, deadtime_pos_to_neg_q};
  assign free_wrap = (cnt_q == 16'hFFFF);
  assign underflow = count_run_bit_q && (mode == tpwm_pkg::MODE_TRI) && down_q && (cnt_q == 16'h0000);
  assign peak = count_run_bit_q && (mode == tpwm_pkg::MODE_TRI) && !down_q && (cnt_q == per);
  // reload only with trough reload enabled and armed by duty1 write
  assign cmp_load = underflow && trough_reload_enable_q && arm_q
    && (!reload_thinning_enable_q || thin_q == 5'h00);

  // counter: only mode limits restart it, never a compare match
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= `TPWM_CNT_RST;
      down_q <= 1'b0;
    end
    else if (!count_run_bit_q)
    begin
      cnt_q <= (mode == tpwm_pkg::MODE_HACC) ? {6'h00, deadtime_neg_to_pos_q} : `TPWM_CNT_RST;
      down_q <= 1'b0;
    end
    else
    begin
      unique case (mode)
        tpwm_pkg::MODE_FREE: cnt_q <= cnt_q + 16'h0001;
        tpwm_pkg::MODE_TRI:
        begin
          if (peak)
          begin
            down_q <= 1'b1;
            cnt_q <= cnt_q; // peak held twice: period (per+1)*2
          end
          else if (underflow)
          begin
            down_q <= 1'b0;
            cnt_q <= cnt_q; // trough held twice as well
          end
          else
            cnt_q <= down_q ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
        end
        tpwm_pkg::MODE_HACC:
        begin
          if (!down_q && cnt_q >= hi_lim - 16'h0002)
          begin
            down_q <= 1'b1;
            cnt_q <= hi_lim;
          end
          else if (down_q && cnt_q <= {6'h00, deadtime_neg_to_pos_q} + 16'h0002)
          begin
            down_q <= 1'b0;
            cnt_q <= {6'h00, deadtime_neg_to_pos_q};
          end
          else
            cnt_q <= down_q ? cnt_q - 16'h0002 : cnt_q + 16'h0002;
        end
        default: cnt_q <= cnt_q;
      endcase
    end
  end

  // reload arm and thinning count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      arm_q <= 1'b0;
      thin_q <= 5'h00;
    end
    else
    begin
      if (cmp_wr[1])
        arm_q <= 1'b1;
      else if (cmp_load)
        arm_q <= 1'b0;
      if (underflow)
        thin_q <= (thin_q == 5'h00) ? irq_thinning_count_q : thin_q - 5'h01;
    end
  end

  // match per channel on its documented step
  logic [5:0] hit;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_hit
      if (gi == 0)
        assign hit[gi] = count_run_bit_q && ((mode == tpwm_pkg::MODE_FREE) ? (cnt_q == per) : peak);
      else
        assign hit[gi] = count_run_bit_q && !down_q && (cnt_q == cmp_of(cmp_act, gi));
    end
  endgenerate

  // outputs: toggle in free mode, pwm level in triangle mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      outs_q <= 6'h00;
    else if (!count_run_bit_q)
      outs_q <= 6'h00;
    else if (mode == tpwm_pkg::MODE_FREE)
    begin
      if (cnt_q == 16'h0000 && outs_q == 6'h00 && !overflow_flag_q)
        outs_q <= 6'h3F;
      else
        outs_q <= outs_q ^ hit;
    end
    else
    begin
      outs_q[0] <= peak ? 1'b1 : (underflow ? 1'b0 : outs_q[0]);
      for (int k = 1; k < 6; k++)
        outs_q[k] <= (cmp_of(cmp_act, k) <= cnt_q);
    end
  end

  // overflow flag: set wins over write-zero clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overflow_flag_q <= 1'b0;
    else if (count_run_bit_q && mode == tpwm_pkg::MODE_FREE && free_wrap)
      overflow_flag_q <= 1'b1;
    else if (!count_run_bit_q)
      overflow_flag_q <= 1'b0;
    else if (wr_en && pready && paddr == `TPWM_STAT_OFS && !pwdata[`TPWM_OVF_BIT])
      overflow_flag_q <= 1'b0;
  end

  // interrupt pulses and pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      match_irqs <= 6'h00;
      overflow_irq <= 1'b0;
      trough_irq <= 1'b0;
      peak_irq <= 1'b0;
      direction_out <= 1'b0;
      pwm_outputs_1_to_5 <= 5'h00;
    end
    else
    begin
      match_irqs <= hit;
      overflow_irq <= count_run_bit_q && mode == tpwm_pkg::MODE_FREE && free_wrap;
      trough_irq <= underflow && (!peak_reload_enable_q || thin_q == 5'h00);
      peak_irq <= peak && peak_irq_enable_q && (thin_q == 5'h00);
      direction_out <= outs_q[0];
      pwm_outputs_1_to_5 <= outs_q[5:1];
    end
  end

  // =====================================================================
  // high-accuracy: three phases with dead time
  logic hacc_run;
  assign hacc_run = count_run_bit_q && (mode == tpwm_pkg::MODE_HACC);
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_dt
      logic [15:0] duty;
      assign duty = cmp_of(cmp_act, gi + 1);
      deadtime_unit #(.W(10)) u_dt (
        .pclk(pclk),
        .presetn(presetn),
        .run(hacc_run),
        .match(hacc_run && (cnt_q[15:1] == duty[15:1])),
        .level(down_q ^ duty[0]),
        .dt_pos(deadtime_neg_to_pos_q),
        .dt_neg(deadtime_pos_to_neg_q),
        .out_pos(deadtime_phase_out[2 * gi]),
        .out_neg(deadtime_phase_out[2 * gi + 1])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// file: verilog/tpwm_regs.svh
// register map, field positions, reset values and mode codes of the pwm timer
// assumes apb byte addressing of word-aligned registers, 32-bit data
`ifndef TPWM_REGS_SVH
`define TPWM_REGS_SVH
// =====================================================================
// register offsets (byte addresses)
`define TPWM_CTRL_OFS 12'h000
`define TPWM_OPT_OFS 12'h004
`define TPWM_STAT_OFS 12'h008
`define TPWM_CNT_OFS 12'h00C
`define TPWM_CMP0_OFS 12'h010
`define TPWM_DT0_OFS 12'h028
`define TPWM_DT1_OFS 12'h02C
`define TPWM_OUT_OFS 12'h030
// =====================================================================
// control fields
`define TPWM_RUN_BIT 0
`define TPWM_MODE_LSB 4
`define TPWM_MODE_FREE 4'h5
`define TPWM_MODE_TRI 4'h7
`define TPWM_MODE_HACC 4'h8
// option fields
`define TPWM_RBE_BIT 0
`define TPWM_RTE_BIT 1
`define TPWM_ICE_BIT 2
`define TPWM_RDE_BIT 3
`define TPWM_ID_LSB 8
// status fields
`define TPWM_OVF_BIT 0
`define TPWM_DIR_BIT 1
`define TPWM_ARM_BIT 2
// reset values
`define TPWM_CNT_RST 16'h0000
`define TPWM_CMP_RST 16'hFFFF
`define TPWM_DT_RST 10'h000
`endif

// file: verilog/tpwm_pkg.sv
// types shared by the pwm timer files
// assumes tpwm_regs.svh for numeric constants
package tpwm_pkg;
  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_FREE = 2'b01,
    MODE_TRI = 2'b10,
    MODE_HACC = 2'b11
  } mode_t;
endpackage

// file: verilog/deadtime_unit.sv
// one dead-time counter: reloads on its phase match, counts down, delays on-edges
// assumes one clock domain with the counter that drives it
`timescale 1ns/100ps
`default_nettype none
module deadtime_unit #(
  parameter int W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic match,
  input wire logic level,
  input wire logic [W-1:0] dt_pos,
  input wire logic [W-1:0] dt_neg,
  output logic out_pos,
  output logic out_neg
);
  logic [W-1:0] cnt_q;
  logic phase_q;
  // reload on match then count down
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= '0;
      phase_q <= 1'b0;
    end
    else if (!run)
    begin
      cnt_q <= '0;
      phase_q <= 1'b0;
    end
    else if (match)
    begin
      cnt_q <= level ? dt_pos : dt_neg;
      phase_q <= level;
    end
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
  end
  // active only once the dead time has run out
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_pos <= 1'b0;
      out_neg <= 1'b0;
    end
    else
    begin
      out_pos <= run && phase_q && (cnt_q == '0) && !match;
      out_neg <= run && !phase_q && (cnt_q == '0) && !match;
    end
  end
endmodule
`default_nettype wire

// file: verilog/cmp_bank.sv
// six compare registers with write buffer and active stage
// assumes load strobe from the mode logic on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "tpwm_regs.svh"
module cmp_bank #(
  parameter int N = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [N-1:0] wr,
  input wire logic [15:0] wdata,
  input wire logic direct,
  input wire logic load,
  output logic [16*N-1:0] buf_out,
  output logic [16*N-1:0] act_out
);
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_cmp
      // buffer written by software, active copied on load or written with it in direct mode
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          buf_out[16*i +: 16] <= `TPWM_CMP_RST;
          act_out[16*i +: 16] <= `TPWM_CMP_RST;
        end
        else
        begin
          if (wr[i])
            buf_out[16*i +: 16] <= wdata;
          if (direct && wr[i])
            act_out[16*i +: 16] <= wdata;
          else if (load)
            act_out[16*i +: 16] <= buf_out[16*i +: 16];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// file: verification/tpwm_checker.sv
// port assertions for the pwm timer
// assumes ctrl writes over apb reveal mode and run
`timescale 1ns/100ps
`default_nettype none
`include "tpwm_regs.svh"
module tpwm_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic direction_out,
  input wire logic [4:0] pwm_outputs_1_to_5,
  input wire logic [5:0] deadtime_phase_out,
  input wire logic [5:0] match_irqs,
  input wire logic overflow_irq,
  input wire logic trough_irq
);
  logic run_q;
  logic [3:0] mode_q;
  logic free_w;
  logic tri_w;
  // ==========================================
  // shadow of run and mode from ctrl writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_q <= 1'b0;
      mode_q <= 4'h0;
    end
    else if (psel && penable && pready && pwrite && paddr == `TPWM_CTRL_OFS)
    begin
      run_q <= pwdata[`TPWM_RUN_BIT];
      mode_q <= pwdata[`TPWM_MODE_LSB +: 4];
    end
  end
  assign free_w = mode_q == `TPWM_MODE_FREE;
  assign tri_w = mode_q == `TPWM_MODE_TRI;
  // ==========================================
  // properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no ready in access phase");
  a_free_start: assert property ($rose(run_q) && free_w |-> ##[1:2] direction_out && &pwm_outputs_1_to_5)
    else $error("outputs not active at start");
  a_free_toggle: assert property (match_irqs[0] && free_w && run_q |-> ##[0:2] direction_out != $past(direction_out, 2))
    else $error("direction pin did not toggle on match");
  a_stop_hold: assert property ($fell(run_q) |=> ##2 $stable({direction_out, pwm_outputs_1_to_5})[*8])
    else $error("outputs moved after stop");
  a_ovf_mode: assert property (overflow_irq |-> free_w && (run_q || $past(run_q)))
    else $error("overflow outside free mode");
  a_trough_mode: assert property (trough_irq |-> tri_w && (run_q || $past(run_q)))
    else $error("trough outside triangle mode");
  a_match_run: assert property (|match_irqs |-> run_q || $past(run_q))
    else $error("match while stopped");
  a_trough_dir: assert property (trough_irq && tri_w |-> ##[0:2] !direction_out)
    else $error("direction not up after trough");
  a_peak_dir: assert property (match_irqs[0] && tri_w |-> ##[0:2] direction_out)
    else $error("direction not down after peak");
  a_phase_gap: assert property (!(|(deadtime_phase_out[4:0] & deadtime_phase_out[5:1] & 5'h15)))
    else $error("pos and neg phase on together");
endmodule
bind tpwm_top tpwm_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .direction_out, .pwm_outputs_1_to_5, .deadtime_phase_out, .match_irqs, .overflow_irq, .trough_irq);
`default_nettype wire

// file: verification/gate_drive_model.sv
// gate driver stand-in: records phase activity and overlap
// assumes phase pins in pos/neg pairs, one clock
`timescale 1ns/100ps
`default_nettype none
module gate_drive_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [5:0] deadtime_phase_out,
  output logic shoot_q,
  output logic [5:0] seen_q
);
  // latch any pair on together, and each phase ever on
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shoot_q <= 1'b0;
      seen_q <= 6'h00;
    end
    else
    begin
      shoot_q <= shoot_q | (|(deadtime_phase_out[4:0] & deadtime_phase_out[5:1] & 5'h15));
      seen_q <= seen_q | deadtime_phase_out;
    end
  end
endmodule
`default_nettype wire

// file: verification/test_tpwm_top.sv
// bench for the pwm timer: apb stimulus, pin and read checks
// assumes checker and gate driver model compiled first
`timescale 1ns/100ps
`default_nettype none
`include "tpwm_regs.svh"
module test_tpwm_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, v;
  logic pready, pslverr, direction_out, overflow_irq, trough_irq, peak_irq, shoot_q;
  logic [4:0] pwm_outputs_1_to_5;
  logic [5:0] deadtime_phase_out, match_irqs, seen_q;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  int mismatches = 0;
  int checked = 0;
  int seed = 32'hDBF3EB4D;
  int n, k, pk;
  int hi[5];
  int rde_a[3] = '{1, 0, 1};
  int id_a[3] = '{1, 3, 0};
  tpwm_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .direction_out, .pwm_outputs_1_to_5, .deadtime_phase_out, .match_irqs, .overflow_irq, .trough_irq, .peak_irq);
  gate_drive_model u_gate (.pclk, .presetn, .deadtime_phase_out, .shoot_q, .seen_q);
  initial forever #25 pclk = ~pclk;
  // ==========================================
  // compare, bus and wait helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge pclk);
      t++;
    end
    while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1)
      mismatches++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m);
    exp_q.push_back({m, x});
    xfer(1'b0, a, 32'h0);
  endtask
  function automatic logic [11:0] ca(input int i);
    return `TPWM_CMP0_OFS + 12'(4 * i);
  endfunction
  function automatic logic [31:0] cv(input logic [3:0] m, input logic r);
    return (32'(m) << `TPWM_MODE_LSB) | 32'(r);
  endfunction
  // duty one written last so it arms the reload
  task automatic cmps(input logic [95:0] c);
    for (int i = 0; i < 6; i++)
      xfer(1'b1, ca((i + 2) % 6), 32'(c[16 * ((i + 2) % 6) +: 16]));
  endtask
  function automatic logic sig(input int w);
    return w == 0 ? trough_irq : w == 1 ? overflow_irq : match_irqs[1];
  endfunction
  task automatic wait_sig(input int w, input int lim);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (sig(w) !== 1'b1 && n < lim);
    if (n >= lim)
      mismatches++;
  endtask
  task automatic win(input int c);
    hi = '{5{0}};
    pk = 0;
    repeat (c)
    begin
      @(posedge pclk);
      for (k = 0; k < 5; k++)
        hi[k] += pwm_outputs_1_to_5[k];
      pk += peak_irq;
    end
  endtask
  task automatic settle();
    wait_sig(0, 300);
    wait_sig(0, 300);
    win(66);
  endtask
  task automatic halt(input logic [3:0] m);
    xfer(1'b1, `TPWM_CTRL_OFS, cv(m, 1'b0));
    repeat (12) @(posedge pclk);
    xfer(1'b1, `TPWM_CTRL_OFS, 32'h0);
  endtask
  task automatic print_verdict();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // read results compared oldest first
  always @(posedge pclk)
  begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      check(prdata & e[63:32], e[31:0]);
    end
  end
  // ==========================================
  // watchdog
  initial
  begin
    #(90000 * 50);
    mismatches++;
    print_verdict();
  end
  // ==========================================
  // main sequence
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b1, 12'h034, 32'($random(seed)));
    for (int i = 0; i < 14; i++)
      rd(12'(4 * i), (i > 3 && i < 10) ? 32'h0000FFFF : 32'h0, 32'hFFFFFFFF);
    for (int i = 1; i < 6; i++)
    begin
      v = 32'($random(seed)) & 32'h0000FFFF;
      xfer(1'b1, ca(i), v);
      rd(ca(i), v, 32'hFFFFFFFF);
    end
    $display("done: registers");
    cmps({16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0020, 16'hFFFF});
    xfer(1'b1, `TPWM_CTRL_OFS, cv(`TPWM_MODE_FREE, 1'b1));
    repeat (3) @(posedge pclk);
    check({direction_out, pwm_outputs_1_to_5}, 6'h3F);
    wait_sig(2, 100);
    repeat (3) @(posedge pclk);
    check({direction_out, pwm_outputs_1_to_5}, 6'h3E);
    wait_sig(1, 70000);
    repeat (3) @(posedge pclk);
    check({direction_out, pwm_outputs_1_to_5}, 6'h00);
    rd(`TPWM_STAT_OFS, 32'h1, 32'h1);
    rd(`TPWM_STAT_OFS, 32'h1, 32'h1);
    xfer(1'b1, `TPWM_STAT_OFS, 32'h0);
    rd(`TPWM_STAT_OFS, 32'h0, 32'h1);
    halt(`TPWM_MODE_FREE);
    $display("done: free running");
    cmps({16'h0008, 16'h0022, 16'h0010, 16'h0021, 16'h0000, 16'h0020});
    xfer(1'b1, `TPWM_OPT_OFS, 32'h1);
    xfer(1'b1, `TPWM_CTRL_OFS, cv(`TPWM_MODE_TRI, 1'b1));
    settle();
    check(n, 66);
    check(hi[0], 66);
    check(hi[1], 0);
    check(hi[2], 34);
    xfer(1'b1, ca(3), 32'h18);
    settle();
    check(hi[2], 34);
    xfer(1'b1, ca(1), 32'h0);
    settle();
    check(hi[2], 18);
    xfer(1'b1, `TPWM_OPT_OFS, 32'h0);
    xfer(1'b1, ca(3), 32'h10);
    xfer(1'b1, ca(1), 32'h0);
    settle();
    check(hi[2], 18);
    for (int i = 0; i < 3; i++)
    begin
      xfer(1'b1, `TPWM_OPT_OFS, 32'(7 | (rde_a[i] << 3) | (id_a[i] << 8)));
      repeat (270) @(posedge pclk);
      win(264);
      check(pk, 4 / (id_a[i] + 1));
    end
    halt(`TPWM_MODE_TRI);
    $display("done: triangle");
    cmps({16'h0000, 16'h0000, 16'h0020, 16'h0020, 16'h0020, 16'h0040});
    xfer(1'b1, `TPWM_DT0_OFS, 32'h4);
    xfer(1'b1, `TPWM_DT1_OFS, 32'h4);
    xfer(1'b1, `TPWM_CTRL_OFS, cv(`TPWM_MODE_HACC, 1'b1));
    repeat (1000) @(posedge pclk);
    check(seen_q, 6'h3F);
    check(shoot_q, 1'b0);
    halt(`TPWM_MODE_HACC);
    $display("done: high accuracy");
    print_verdict();
  end
endmodule
`default_nettype wire
